// ==== bct_defs.svh ====
// Purpose: Constants for the bus cycle termination block
// Assumes: One core clock; all bus logic works on its falling edge
// Notes:   Included by the core; the package does not include it
// How it works
// - Wait states in S4 until termination seen
// - Read data latched one edge after acknowledge
// - Termination inputs sampled on falling clock edge
// - Acknowledge alone ends cycle normally
// - Halt with acknowledge ends, then waits release
// - Bus fault without halt starts fault exception
// - Fault plus halt ends cycle, then retries
// - Fault released before halt reruns the cycle
// - Wrong release order traps through vector zero
// - Late halt release may stretch next cycle
// - Lingering fault ends next cycle as fault
// - Exactly one of normal, exception, halted
// - Stop enters quiet substate without bus use
// - Interrupt, fault, reset, traps enter exception
// - Fault during fault exception halts the core
// - Only reset leaves the halted state
`ifndef BCT_DEFS_SVH
`define BCT_DEFS_SVH

`define BCT_CLK_PERIOD_NS 100
`define BCT_ADDR_W        32
`define BCT_DATA_W        16
`define BCT_FC_W          3
`define BCT_VEC_W         8
`define BCT_VEC_ILLEGAL   8'h00
`define BCT_VEC_BUS_FAULT 8'h02

`endif

// ==== bct_pkg.sv ====
// Purpose: Types shared by the bus cycle termination block
// Assumes: Encodings are local to this block
// Notes:   Bus states run Gray along the usual path up to ENDC
package bct_pkg;

  // Bus cycle states; ADDR, STRB, DLAT and ENDC take one clock each
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_STRB = 3'h3,
    ST_WAIT = 3'h2,
    ST_DLAT = 3'h6,
    ST_ENDC = 3'h7,
    ST_HOLD = 3'h5
  } bct_bus_e;

  // Processing state of the core
  typedef enum logic [1:0] {
    PR_NORMAL = 2'h0,
    PR_EXCEPT = 2'h1,
    PR_HALTED = 2'h3
  } bct_proc_e;

  // How a cycle ended
  typedef enum logic [2:0] {
    TM_NORMAL  = 3'h0,
    TM_HALT    = 3'h1,
    TM_BERR    = 3'h3,
    TM_RETRY   = 3'h2,
    TM_ILLEGAL = 3'h6
  } bct_term_e;

endpackage : bct_pkg

// ==== bct_sync.sv ====
// Purpose: Two-stage falling-edge synchroniser for a group of pins
// Assumes: Inputs have no phase relation to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none

module bct_sync #(
  parameter int W       = 1,
  parameter bit RST_ONE = 1'b0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } bct_sync_s;

  bct_sync_s r;
  bct_sync_s n;

  // Shift one stage per falling edge
  always_comb begin
    n    = r;
    n.s1 = async_in;
    n.s2 = r.s1;
  end

  // Falling edge keeps the sample point of the pins
  always_ff @(negedge clk or posedge rst) begin
    if (rst) begin
      r <= {2 * W{RST_ONE}};
    end else begin
      r <= n;
    end
  end

  assign sync_out = r.s2;

endmodule : bct_sync

`default_nettype wire

// ==== bct_core.sv ====
// Purpose: Decide how each bus cycle ends and track processing state
// Assumes: Core microcode issues cycles and handles exception stacking
// Notes:   All state moves on the falling edge of clk
`timescale 1ns/1ns
`default_nettype none
`include "bct_defs.svh"

module bct_core #(
  parameter int          AW           = `BCT_ADDR_W,
  parameter int          DW           = `BCT_DATA_W,
  parameter logic [7:0]  VEC_BUS_FAULT = `BCT_VEC_BUS_FAULT
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  transfer_ack_n,
  input  wire logic                  bus_fault_n,
  input  wire logic                  halt_request_n,
  input  wire logic [DW-1:0]         data_pin,
  input  wire logic                  cyc_req,
  input  wire logic [AW-1:0]         cyc_addr,
  input  wire logic [`BCT_FC_W-1:0]  cyc_fc,
  input  wire logic                  cyc_read,
  input  wire logic                  cyc_word,
  output logic                       cyc_ready,
  output logic                       cyc_done,
  output logic [2:0]                 cyc_status,
  output logic [DW-1:0]              rd_data,
  output logic                       addr_strobe_n,
  output logic [AW-1:0]              bus_addr,
  output logic [`BCT_FC_W-1:0]       bus_fc,
  output logic                       bus_read,
  output logic                       bus_word,
  input  wire logic                  exc_req,
  input  wire logic [`BCT_VEC_W-1:0] exc_req_vec,
  input  wire logic                  exc_done,
  input  wire logic                  stop_exec,
  output logic                       exc_start,
  output logic [`BCT_VEC_W-1:0]      exc_vector,
  output logic [1:0]                 proc_state,
  output logic                       stopped
);

  typedef struct packed {
    bct_pkg::bct_bus_e      st;
    bct_pkg::bct_proc_e     proc;
    bct_pkg::bct_term_e     kind;
    bct_pkg::bct_term_e     status;
    logic                   stopped;
    logic                   berr_gone;
    logic                   exc_berr;
    logic                   as_n;
    logic                   done;
    logic                   exc_start;
    logic [`BCT_VEC_W-1:0]  exc_vec;
    logic [AW-1:0]          addr;
    logic [`BCT_FC_W-1:0]   fc;
    logic                   rd;
    logic                   wd;
    logic [DW-1:0]          data;
  } bct_core_s;

  bct_core_s r;
  bct_core_s n;

  logic [2:0]    ctl_s;
  logic [DW-1:0] data_s;
  logic          ack_w;
  logic          berr_w;
  logic          halt_w;

  // Control pins idle high, so their stages reset to ones
  bct_sync #(
    .W       (3),
    .RST_ONE (1'b1)
  ) u_ctl_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({halt_request_n, bus_fault_n, transfer_ack_n}),
    .sync_out (ctl_s)
  );

  // Data gets the same delay so it stays aligned with acknowledge
  bct_sync #(
    .W       (DW),
    .RST_ONE (1'b0)
  ) u_data_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (data_pin),
    .sync_out (data_s)
  );

  // Asserted levels as seen internally
  assign ack_w  = ~ctl_s[0];
  assign berr_w = ~ctl_s[1];
  assign halt_w = ~ctl_s[2];

  // New cycles wait while halt lingers, stretching the next cycle
  assign cyc_ready = (r.st == bct_pkg::ST_IDLE) && !halt_w
                     && (r.proc != bct_pkg::PR_HALTED) && !r.stopped;

  // Bus cycle sequencing and termination decision
  always_comb begin
    n           = r;
    n.done      = 1'b0;
    n.exc_start = 1'b0;
    unique case (r.st)
      bct_pkg::ST_IDLE: begin
        if (cyc_ready && cyc_req) begin
          n.addr = cyc_addr;
          n.fc   = cyc_fc;
          n.rd   = cyc_read;
          n.wd   = cyc_word;
          n.st   = bct_pkg::ST_ADDR;
        end
      end
      bct_pkg::ST_ADDR: begin
        n.as_n = 1'b0;
        n.st   = bct_pkg::ST_STRB;
      end
      bct_pkg::ST_STRB: begin
        n.st = bct_pkg::ST_WAIT;
      end
      bct_pkg::ST_WAIT: begin
        // Fault with halt wins, then fault, then acknowledge
        if (berr_w && halt_w) begin
          n.kind = bct_pkg::TM_RETRY;
          n.as_n = 1'b1;
          n.st   = bct_pkg::ST_ENDC;
        end else if (berr_w) begin
          n.kind = bct_pkg::TM_BERR;
          n.as_n = 1'b1;
          n.st   = bct_pkg::ST_ENDC;
        end else if (ack_w) begin
          n.kind = halt_w ? bct_pkg::TM_HALT : bct_pkg::TM_NORMAL;
          n.st   = bct_pkg::ST_DLAT;
        end
        // Halt alone keeps waiting: a later fault makes it a retry
      end
      bct_pkg::ST_DLAT: begin
        if (r.rd) begin
          n.data = data_s;
        end
        n.as_n = 1'b1;
        n.st   = bct_pkg::ST_ENDC;
      end
      bct_pkg::ST_ENDC: begin
        n.berr_gone = 1'b0;
        if (r.kind == bct_pkg::TM_HALT || r.kind == bct_pkg::TM_RETRY) begin
          n.st = bct_pkg::ST_HOLD;
        end else begin
          n.done   = 1'b1;
          n.status = r.kind;
          n.st     = bct_pkg::ST_IDLE;
        end
      end
      bct_pkg::ST_HOLD: begin
        // Fault must be seen released a clock before halt
        n.berr_gone = r.berr_gone | ~berr_w;
        if (!halt_w) begin
          if (r.kind == bct_pkg::TM_HALT) begin
            n.done   = 1'b1;
            n.status = bct_pkg::TM_HALT;
            n.st     = bct_pkg::ST_IDLE;
          end else if (r.berr_gone) begin
            n.st   = bct_pkg::ST_ADDR;
          end else begin
            n.done   = 1'b1;
            n.status = bct_pkg::TM_ILLEGAL;
            n.st     = bct_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        n.as_n = 1'b1;
        n.st   = bct_pkg::ST_IDLE;
      end
    endcase

    // Processing state; halted is left only through rst
    if (r.proc == bct_pkg::PR_HALTED) begin
      n.proc = bct_pkg::PR_HALTED;
    end else if (n.done && n.status == bct_pkg::TM_BERR) begin
      if (r.proc == bct_pkg::PR_EXCEPT && r.exc_berr) begin
        n.proc = bct_pkg::PR_HALTED;
      end else begin
        n.proc      = bct_pkg::PR_EXCEPT;
        n.exc_start = 1'b1;
        n.exc_vec   = VEC_BUS_FAULT;
        n.exc_berr  = 1'b1;
        n.stopped   = 1'b0;
      end
    end else if (n.done && n.status == bct_pkg::TM_ILLEGAL) begin
      n.proc      = bct_pkg::PR_EXCEPT;
      n.exc_start = 1'b1;
      n.exc_vec   = `BCT_VEC_ILLEGAL;
      n.exc_berr  = 1'b0;
      n.stopped   = 1'b0;
    end else if (exc_req && r.proc == bct_pkg::PR_NORMAL) begin
      n.proc      = bct_pkg::PR_EXCEPT;
      n.exc_start = 1'b1;
      n.exc_vec   = exc_req_vec;
      n.exc_berr  = 1'b0;
      n.stopped   = 1'b0;
    end else if (exc_done && r.proc == bct_pkg::PR_EXCEPT) begin
      n.proc     = bct_pkg::PR_NORMAL;
      n.exc_berr = 1'b0;
    end else if (stop_exec && r.proc == bct_pkg::PR_NORMAL
                 && r.st == bct_pkg::ST_IDLE) begin
      n.stopped = 1'b1;
    end
  end

  // Reset puts the core into reset exception processing
  always_ff @(negedge clk or posedge rst) begin
    if (rst) begin
      r      <= '0;
      r.proc <= bct_pkg::PR_EXCEPT;
      r.as_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from state flip-flops
  assign cyc_done      = r.done;
  assign cyc_status    = r.status;
  assign rd_data       = r.data;
  assign addr_strobe_n = r.as_n;
  assign bus_addr      = r.addr;
  assign bus_fc        = r.fc;
  assign bus_read      = r.rd;
  assign bus_word      = r.wd;
  assign exc_start     = r.exc_start;
  assign exc_vector    = r.exc_vec;
  assign proc_state    = r.proc;
  assign stopped       = r.stopped;

  // Checks on the falling edge, quiet in reset
  wait_hold_a: assert property (
    @(negedge clk) disable iff (rst)
    (r.st == bct_pkg::ST_WAIT && !ack_w && !berr_w)
      |=> (r.st == bct_pkg::ST_WAIT && !r.as_n))
    else $error("wait state left without termination");

  data_latch_a: assert property (
    @(negedge clk) disable iff (rst)
    (r.st == bct_pkg::ST_DLAT && r.rd) |=> (rd_data == $past(data_s)))
    else $error("read data not latched after acknowledge");

  normal_end_a: assert property (
    @(negedge clk) disable iff (rst)
    (r.st == bct_pkg::ST_WAIT && ack_w && !berr_w && !halt_w)
      |=> r.st == bct_pkg::ST_DLAT ##1 r.st == bct_pkg::ST_ENDC
      ##1 (cyc_done && cyc_status == bct_pkg::TM_NORMAL))
    else $error("normal end not reported in three edges");

  halt_hold_a: assert property (
    @(negedge clk) disable iff (rst)
    (r.st == bct_pkg::ST_HOLD && halt_w) |=> (r.st == bct_pkg::ST_HOLD && !cyc_done))
    else $error("held cycle left while halt asserted");

  fault_end_a: assert property (
    @(negedge clk) disable iff (rst)
    (r.st == bct_pkg::ST_WAIT && berr_w && !halt_w)
      |=> r.st == bct_pkg::ST_ENDC
      ##1 (cyc_done && cyc_status == bct_pkg::TM_BERR))
    else $error("bus fault end not reported");

  retry_hold_a: assert property (
    @(negedge clk) disable iff (rst)
    (r.st == bct_pkg::ST_WAIT && berr_w && halt_w)
      |=> r.st == bct_pkg::ST_ENDC ##1 r.st == bct_pkg::ST_HOLD)
    else $error("retry did not hold the bus");

  rerun_same_a: assert property (
    @(negedge clk) disable iff (rst)
    (r.st == bct_pkg::ST_HOLD && r.kind == bct_pkg::TM_RETRY && r.berr_gone && !halt_w)
      |=> (r.st == bct_pkg::ST_ADDR && $stable(bus_addr) && $stable(bus_fc)
           && $stable(bus_read) && $stable(bus_word)))
    else $error("rerun did not repeat the cycle");

  illegal_vec_a: assert property (
    @(negedge clk) disable iff (rst)
    (r.st == bct_pkg::ST_HOLD && r.kind == bct_pkg::TM_RETRY && !r.berr_gone
     && !halt_w && r.proc != bct_pkg::PR_HALTED)
      |=> (exc_start && exc_vector == `BCT_VEC_ILLEGAL))
    else $error("illegal release did not trap to vector zero");

  one_state_a: assert property (
    @(negedge clk) disable iff (rst)
    (r.proc == bct_pkg::PR_NORMAL || r.proc == bct_pkg::PR_EXCEPT
     || r.proc == bct_pkg::PR_HALTED) && !(r.stopped && r.proc != bct_pkg::PR_NORMAL))
    else $error("processing state code invalid");

  stop_quiet_a: assert property (
    @(negedge clk) disable iff (rst)
    (stopped && r.st == bct_pkg::ST_IDLE) |=> (r.st == bct_pkg::ST_IDLE && addr_strobe_n))
    else $error("bus cycle started while stopped");

  double_fault_a: assert property (
    @(negedge clk) disable iff (rst)
    (r.proc == bct_pkg::PR_EXCEPT && r.exc_berr && n.done && n.status == bct_pkg::TM_BERR)
      |=> (proc_state == bct_pkg::PR_HALTED && !exc_start))
    else $error("second bus fault did not halt");

  halted_stay_a: assert property (
    @(negedge clk) disable iff (rst)
    (r.proc == bct_pkg::PR_HALTED) |=> (r.proc == bct_pkg::PR_HALTED && !cyc_ready))
    else $error("halted state left without reset");

endmodule : bct_core

`default_nettype wire

// ==== bct_slave_model.sv ====
// Purpose: Behavioural slave and termination logic facing the core
// Assumes: Bench sets mode and wait count between cycles
// Notes:   Released pins go high as pulled-up lines would
`timescale 1ns/1ns
`default_nettype none

module bct_slave_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        addr_strobe_n,
  input  wire logic [2:0]  mode,
  input  wire logic [3:0]  wait_n,
  input  wire logic [15:0] rd_val,
  output logic             ack_n,
  output logic             fault_n,
  output logic             halt_n,
  output logic [15:0]      data
);
  logic [3:0] cnt_r;
  logic [1:0] rel_r;

  // Mode 0 ack, 1 ack+halt, 2 fault, 3 retry, 4 retry released in wrong order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r   <= 4'h0;
      rel_r   <= 2'h0;
      ack_n   <= 1'b1;
      fault_n <= 1'b1;
      halt_n  <= 1'b1;
      data    <= 16'h0;
    end else if (!addr_strobe_n && cnt_r != wait_n) begin
      cnt_r <= cnt_r + 4'h1;
      data  <= ~data;  // Undriven bus must not look stable
    end else if (!addr_strobe_n) begin
      ack_n   <= mode >= 3'h2;
      fault_n <= mode < 3'h2;
      halt_n  <= !(mode == 3'h1 || mode >= 3'h3);
      data    <= rd_val;
    end else begin
      // Strobe gone: drop ack and fault at once, keep halt two clocks longer unless mode 4
      cnt_r   <= 4'h0;
      ack_n   <= 1'b1;
      fault_n <= 1'b1;
      data    <= ~data;
      rel_r   <= halt_n ? 2'h0 : rel_r + 2'h1;
      if (mode == 3'h4 || rel_r == 2'h2) halt_n <= 1'b1;
    end
  end
endmodule : bct_slave_model
`default_nettype wire

// ==== bus_cycle_termination_control_tb.sv ====
// Purpose: Self-checking bench for the cycle termination core
// Assumes: Slave model answers each cycle as the bench commands
// Notes:   Bench drives on rising edges, core works on falling ones
`timescale 1ns/1ns
`default_nettype none

module bus_cycle_termination_control_tb;
  logic        clk, rst, cyc_req, cyc_read, cyc_word, exc_req, exc_done, stop_exec;
  logic        transfer_ack_n, bus_fault_n, halt_request_n, cyc_ready, cyc_done;
  logic        addr_strobe_n, bus_read, bus_word, exc_start, stopped;
  logic [15:0] data_pin, rd_data, sl_val;
  logic [31:0] cyc_addr, bus_addr;
  logic [2:0]  cyc_fc, bus_fc, cyc_status, sl_mode;
  logic [7:0]  exc_req_vec, exc_vector;
  logic [3:0]  sl_wait;
  logic [1:0]  proc_state;
  int          error_cnt, checked;

  // Free-running core clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  bct_core dut_u (.clk, .rst, .transfer_ack_n, .bus_fault_n, .halt_request_n, .data_pin, .cyc_req,
    .cyc_addr, .cyc_fc, .cyc_read, .cyc_word, .cyc_ready, .cyc_done, .cyc_status, .rd_data,
    .addr_strobe_n, .bus_addr, .bus_fc, .bus_read, .bus_word, .exc_req, .exc_req_vec, .exc_done,
    .stop_exec, .exc_start, .exc_vector, .proc_state, .stopped);

  bct_slave_model slave_u (.clk, .rst, .addr_strobe_n, .mode(sl_mode), .wait_n(sl_wait),
    .rd_val(sl_val), .ack_n(transfer_ack_n), .fault_n(bus_fault_n), .halt_n(halt_request_n),
    .data(data_pin));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  task automatic do_reset;
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("proc", 32'h1, proc_state);
    chk("strobe", 32'h1, addr_strobe_n);
  endtask : do_reset

  // One-cycle pulse: 0 exception done, 1 exception request, 2 stop
  // The entry strobe lasts one clock, so it is judged at the very next edge
  task automatic pulse(input int k, input logic exp_start);
    @(posedge clk);
    exc_done    <= k == 0;
    exc_req     <= k == 1;
    stop_exec   <= k == 2;
    exc_req_vec <= 8'h40;
    @(posedge clk);
    chk("exc_start", {31'h0, exp_start}, {31'h0, exc_start});
    exc_done  <= 1'b0;
    exc_req   <= 1'b0;
    stop_exec <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse

  // Full cycle; releases retry mode once halt has been seen and dropped
  task automatic run_cyc(input logic [2:0] m, input logic [3:0] w, input logic [2:0] st, output int lat);
    int n;
    bit hs;
    logic [15:0] prev;
    hs = 1'b0;
    @(posedge clk);
    prev     = rd_data;
    sl_mode  <= m;
    sl_wait  <= w;
    sl_val   <= 16'ha5c3 ^ {12'h0, w};
    cyc_addr <= 32'h00a0_1230 + {29'h0, m};
    cyc_read <= m != 3'h1; // Halt-end cycle is a write, so it must not latch
    cyc_word <= ~w[0];
    cyc_req  <= 1'b1;
    for (n = 0; n < 80 && cyc_ready !== 1'b1; n++) @(posedge clk);
    @(posedge clk);
    cyc_req <= 1'b0;
    for (lat = 1; lat < 80 && cyc_done !== 1'b1; lat++) begin
      @(posedge clk);
      if (halt_request_n === 1'b0) hs = 1'b1;
      else if (hs) sl_mode <= 3'h0;
    end
    if (n == 80 || lat == 80) begin
      chk("timeout", 32'h0, 32'h1);
      conclude();
    end else begin
      chk("status", st, cyc_status);
      chk("addr", cyc_addr, bus_addr);
      chk("fc", 32'h5, bus_fc);
      chk("read", {31'h0, m != 3'h1}, {31'h0, bus_read});
      chk("word", {31'h0, ~w[0]}, {31'h0, bus_word});
      // Only acknowledged reads latch; writes and faulted cycles keep the old word
      chk("rd_data", (m == 3'h0 || m == 3'h3) ? sl_val : prev, rd_data);
    end
  endtask : run_cyc

  task automatic t_normal;
    int a, b;
    pulse(0, 1'b0);
    chk("proc", 32'h0, proc_state);
    run_cyc(3'h0, 4'h0, 3'h0, a);
    run_cyc(3'h0, 4'h3, 3'h0, b);
    chk("waits", 32'd3, b - a);
    run_cyc(3'h1, 4'h1, 3'h1, a);
    run_cyc(3'h3, 4'h2, 3'h0, a);
    $display("test cycle ends done");
  endtask : t_normal

  task automatic t_illegal;
    int a;
    run_cyc(3'h4, 4'h0, 3'h6, a);
    repeat (3) @(posedge clk);
    chk("vector", 32'h0, exc_vector);
    chk("proc", 32'h1, proc_state);
    pulse(0, 1'b0);
    $display("test illegal release done");
  endtask : t_illegal

  task automatic t_stop;
    pulse(2, 1'b0);
    chk("stopped", 32'h1, stopped);
    chk("ready", 32'h0, cyc_ready);
    chk("proc", 32'h0, proc_state);
    pulse(1, 1'b1);
    chk("stopped", 32'h0, stopped);
    chk("proc", 32'h1, proc_state);
    chk("vector", 32'h40, exc_vector);
    pulse(0, 1'b0);
    $display("test stop done");
  endtask : t_stop

  task automatic t_fault;
    int a;
    run_cyc(3'h2, 4'h1, 3'h3, a);
    repeat (3) @(posedge clk);
    chk("vector", 32'h2, exc_vector);
    chk("proc", 32'h1, proc_state);
    run_cyc(3'h2, 4'h0, 3'h3, a);
    repeat (3) @(posedge clk);
    chk("proc", 32'h3, proc_state);
    pulse(1, 1'b0);
    pulse(0, 1'b0);
    chk("proc", 32'h3, proc_state);
    chk("ready", 32'h0, cyc_ready);
    do_reset();
    $display("test fault done");
  endtask : t_fault

  // Main sequence
  initial begin
    rst         = 1'b1;
    cyc_req     = 1'b0;
    cyc_addr    = 32'h0;
    cyc_fc      = 3'h5;
    cyc_read    = 1'b1;
    cyc_word    = 1'b1;
    exc_req     = 1'b0;
    exc_req_vec = 8'h0;
    exc_done    = 1'b0;
    stop_exec   = 1'b0;
    sl_mode     = 3'h0;
    sl_wait     = 4'h0;
    sl_val      = 16'h0;
    error_cnt   = 0;
    checked     = 0;
    do_reset();
    t_normal();
    // Stop test leaves a nonzero vector, so the illegal trap must visibly change it
    t_stop();
    t_illegal();
    t_fault();
    conclude();
  end
endmodule : bus_cycle_termination_control_tb
`default_nettype wire
